// ===== logic/soc_params.svh
// Purpose: Named offsets, field positions, reset values and timeout periods in ns for the output configuration block.
// Assumes: 10 MHz clock, registers at their printed offsets.
// Notes:   Definitions only.
`ifndef SOC_PARAMS_SVH
`define SOC_PARAMS_SVH

`define SOC_OFS_OUT1        8'h11
`define SOC_OFS_OUT2        8'h15
`define SOC_OFS_OUT3        8'h1C
`define SOC_OFS_OUT4        8'h23
`define SOC_OFS_OUT5        8'h2A
`define SOC_OFS_OUT6        8'h31
`define SOC_OFS_OUT7        8'h35
`define SOC_OFS_OUT8        8'h39
`define SOC_OFS_POLARITY    8'h3A
`define SOC_REBOOT_CMD      8'h88
`define SOC_CFG_RESET       8'h00
`define SOC_POL_RESET       8'hFF
`define SOC_NUM_OUT         8
`define SOC_NUM_REG         9
`define SOC_POL_IDX         4'h8
// Low-stage outputs (3-bit field): timeout [3:1] with stage [6:4], or timeout [4:2] with stage [7:5]
`define SOC_TMO_LO_A        1
`define SOC_TMO_LO_B        2
`define SOC_STG3_LO_A       4
`define SOC_STG3_LO_B       5
`define SOC_STG4_LSB        4
// Stage codes
`define SOC_S3_OD           3'h0
`define SOC_S3_PU_ABP       3'h5
`define SOC_S3_CP           3'h6
`define SOC_S4_OD           4'h0
`define SOC_S4_PU_ABP       4'h5
`define SOC_S4_PP_FIRST     4'h6
`define SOC_S4_PP_LAST8     4'h9
`define SOC_S4_PP_LAST5     4'h7
`define SOC_S3_PU_LAST8     3'h4
`define SOC_S3_PU_LAST5     3'h2
`define SOC_S4_PU_LAST8     4'h4
`define SOC_S4_PU_LAST5     4'h2
// Timeout periods in ns
`define SOC_CLK_NS          100
`define SOC_T0_NS           25000
`define SOC_T1_NS           1562500
`define SOC_T2_NS           6250000
`define SOC_T3_NS           25000000
`define SOC_T4_NS           50000000
`define SOC_T5_NS           200000000
`define SOC_T6_NS           400000000
`define SOC_T7_NS           1600000000

`endif

// ===== logic/soc_pkg.sv
// Purpose: Types shared by the output configuration block.
// Assumes: Nothing beyond the params header.
// Notes:   Stage kinds as decoded for each output.
`default_nettype none
package soc_pkg;
  typedef enum logic [2:0] {
    soc_open_drain,
    soc_weak_pullup,
    soc_push_pull,
    soc_charge_pump
  } soc_stage_e;
  typedef logic [31:0] soc_count_t;
endpackage
`default_nettype wire

// ===== logic/soc_stage_decode.sv
// Purpose: Decode one output's stage and timeout fields into kind, reference and period count.
// Assumes: Register byte as stored; variant and channel given as constants.
// Notes:   Purely combinational.
`include "soc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module soc_stage_decode
  import soc_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter bit FIVE_OUT = 1'b0
) (
  input  wire logic [7:0] cfg,
  output soc_stage_e      kind,
  output logic [2:0]      ref_sel,
  output soc_count_t      period
);
  // Upper channels carry the 4-bit field with push-pull; lower carry 3-bit with charge pump
  localparam bit WIDE = FIVE_OUT ? (CHANNEL >= 2) : (CHANNEL >= 4);
  localparam bit HIGH_POS = FIVE_OUT ? 1'b1 : (CHANNEL >= 2);
  logic [2:0] stg3;
  logic [3:0] stg4;
  logic [2:0] tmo;

  function automatic soc_count_t cycles(input logic [2:0] code);
    case (code)
      3'h0:    cycles = soc_count_t'(`SOC_T0_NS / `SOC_CLK_NS);
      3'h1:    cycles = soc_count_t'(`SOC_T1_NS / `SOC_CLK_NS);
      3'h2:    cycles = soc_count_t'(`SOC_T2_NS / `SOC_CLK_NS);
      3'h3:    cycles = soc_count_t'(`SOC_T3_NS / `SOC_CLK_NS);
      3'h4:    cycles = soc_count_t'(`SOC_T4_NS / `SOC_CLK_NS);
      3'h5:    cycles = soc_count_t'(`SOC_T5_NS / `SOC_CLK_NS);
      3'h6:    cycles = soc_count_t'(`SOC_T6_NS / `SOC_CLK_NS);
      default: cycles = soc_count_t'(`SOC_T7_NS / `SOC_CLK_NS);
    endcase
  endfunction

  always_comb begin
    stg4 = cfg[`SOC_STG4_LSB +: 4];
    if (WIDE) begin
      stg3 = 3'h0;
      tmo  = cfg[`SOC_TMO_LO_A +: 3];
    end else if (HIGH_POS) begin
      stg3 = cfg[`SOC_STG3_LO_B +: 3];
      tmo  = cfg[`SOC_TMO_LO_B +: 3];
    end else begin
      stg3 = cfg[`SOC_STG3_LO_A +: 3];
      tmo  = cfg[`SOC_TMO_LO_A +: 3];
    end
    period  = cycles(tmo);
    kind    = soc_open_drain;
    ref_sel = 3'h0;
    if (WIDE) begin
      if (stg4 != `SOC_S4_OD &&
          stg4 <= (FIVE_OUT ? `SOC_S4_PU_LAST5 : `SOC_S4_PU_LAST8)) begin
        kind    = soc_weak_pullup;
        ref_sel = stg4[2:0] - 3'h1;
      end else if (stg4 == `SOC_S4_PU_ABP) begin
        kind    = soc_weak_pullup;
        ref_sel = 3'h4;
      end else if (stg4 >= `SOC_S4_PP_FIRST &&
                   stg4 <= (FIVE_OUT ? `SOC_S4_PP_LAST5 : `SOC_S4_PP_LAST8)) begin
        kind    = soc_push_pull;
        ref_sel = 3'(stg4 - `SOC_S4_PP_FIRST);
      end
    end else begin
      if (stg3 != `SOC_S3_OD &&
          stg3 <= (FIVE_OUT ? `SOC_S3_PU_LAST5 : `SOC_S3_PU_LAST8)) begin
        kind    = soc_weak_pullup;
        ref_sel = stg3 - 3'h1;
      end else if (stg3 == `SOC_S3_PU_ABP) begin
        kind    = soc_weak_pullup;
        ref_sel = 3'h4;
      end else if (stg3 == `SOC_S3_CP) begin
        kind = soc_charge_pump;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/soc_output_config.sv
// Purpose: Volatile output configuration registers and per-output drive control.
// Assumes: Serial front end delivers decoded byte writes, reads and commands.
// Notes:   Outputs are registered; FIVE_OUT selects the five-output variant.
//
// Function
// - Polarity bit per output: 0 asserts low, 1 asserts high.
// - Eight-output outputs 1-4: 3-bit stage, open drain, pullups, charge pump.
// - Eight-output outputs 5-8: 4-bit stage, open drain, pullups, push-pull.
// - Five-output outputs 1-2: codes 011 and 100 unused.
// - Five-output outputs 3-5: push-pull only to inputs one and two (ref_sel 0 and 1).
// - Three-bit timeout code selects period from 25us to 1600ms.
// - Charge pump only on the low-group outputs.
// - Push-pull only on the high-group outputs, referencing one monitored input.
// - Every output accepts weak pullup to an input or internal rail.
// - Open drain only pulls low or floats, never drives high.
// - Defaults are 00h everywhere, polarity FFh: active high, open drain.
// - Reboot command 88h reloads volatile registers from nonvolatile store.
`include "soc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module soc_output_config
  import soc_pkg::*;
#(
  parameter bit FIVE_OUT = 1'b0
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  input  wire logic [7:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       cmd_valid,
  input  wire logic [7:0]                 cmd_byte,
  input  wire logic [8*`SOC_NUM_REG-1:0]  nv_image,
  input  wire logic [`SOC_NUM_OUT-1:0]    assert_req,
  output logic      [7:0]                 rdata,
  output logic                            rd_valid,
  output logic                            rd_error,
  output logic                            reloading,
  output logic      [`SOC_NUM_OUT-1:0]    pin_drive_low,
  output logic      [`SOC_NUM_OUT-1:0]    pin_drive_high,
  output logic      [`SOC_NUM_OUT-1:0]    pin_pullup_en,
  output logic      [`SOC_NUM_OUT-1:0]    pin_pump_en,
  output logic      [3*`SOC_NUM_OUT-1:0]  pin_ref_sel,
  output logic      [`SOC_NUM_OUT-1:0]    deassert_done
);
  logic [7:0]  regs [`SOC_NUM_REG];
  soc_stage_e  kind [`SOC_NUM_OUT];
  logic [2:0]  rsel [`SOC_NUM_OUT];
  soc_count_t  period [`SOC_NUM_OUT];
  soc_count_t  tcount [`SOC_NUM_OUT];
  logic [`SOC_NUM_OUT-1:0] active;
  logic [`SOC_NUM_OUT-1:0] level;
  logic [7:0]              pol_used;

  // Returns register index for an address, or NUM_REG when unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `SOC_OFS_OUT1:     reg_index = 4'h0;
      `SOC_OFS_OUT2:     reg_index = 4'h1;
      `SOC_OFS_OUT3:     reg_index = 4'h2;
      `SOC_OFS_OUT4:     reg_index = 4'h3;
      `SOC_OFS_OUT5:     reg_index = 4'h4;
      `SOC_OFS_OUT6:     reg_index = 4'h5;
      `SOC_OFS_OUT7:     reg_index = 4'h6;
      `SOC_OFS_OUT8:     reg_index = 4'h7;
      `SOC_OFS_POLARITY: reg_index = `SOC_POL_IDX;
      default:           reg_index = 4'(`SOC_NUM_REG);
    endcase
  endfunction

  // Five-output variant maps its outputs onto offsets 1Ch..35h and polarity bits 2..6
  localparam int BASE = FIVE_OUT ? 2 : 0;
  localparam int NUSED = FIVE_OUT ? 5 : 8;

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `SOC_NUM_REG; i++) begin
        regs[i] <= `SOC_CFG_RESET;
      end
      regs[`SOC_POL_IDX] <= `SOC_POL_RESET;
      reloading <= 1'b0;
    end else if (clk_en) begin
      reloading <= 1'b0;
      if (cmd_valid && cmd_byte == `SOC_REBOOT_CMD) begin
        // Reload has priority over a same-cycle write so the image is restored whole
        for (int i = 0; i < `SOC_NUM_REG; i++) begin
          regs[i] <= nv_image[8*i +: 8];
        end
        reloading <= 1'b1;
      end else if (wr_en && reg_index(addr) != 4'(`SOC_NUM_REG)) begin
        regs[reg_index(addr)] <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_en && reg_index(addr) != 4'(`SOC_NUM_REG);
      rd_error <= rd_en && reg_index(addr) == 4'(`SOC_NUM_REG);
      if (rd_en && reg_index(addr) != 4'(`SOC_NUM_REG)) begin
        rdata <= regs[reg_index(addr)];
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SOC_NUM_OUT; g++) begin : gen_out
      if (g < NUSED) begin : gen_used
        soc_stage_decode #(
          .CHANNEL  (g),
          .FIVE_OUT (FIVE_OUT)
        ) u_dec (
          .cfg     (regs[g + BASE]),
          .kind    (kind[g]),
          .ref_sel (rsel[g]),
          .period  (period[g])
        );
      end else begin : gen_unused
        assign kind[g]   = soc_open_drain;
        assign rsel[g]   = 3'h0;
        assign period[g] = '0;
      end
    end
  endgenerate

  // Assertion follows the request at once; release waits the timeout period
  always_ff @(posedge clock) begin
    if (rst) begin
      active        <= '0;
      deassert_done <= '0;
      for (int i = 0; i < `SOC_NUM_OUT; i++) begin
        tcount[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < `SOC_NUM_OUT; i++) begin
        deassert_done[i] <= 1'b0;
        if (i >= NUSED) begin
          active[i] <= 1'b0;
          tcount[i] <= '0;
        end else if (assert_req[i]) begin
          active[i] <= 1'b1;
          tcount[i] <= '0;
        end else if (active[i]) begin
          if (tcount[i] + 32'h1 >= period[i]) begin
            active[i]        <= 1'b0;
            deassert_done[i] <= 1'b1;
            tcount[i]        <= '0;
          end else begin
            tcount[i] <= tcount[i] + 32'h1;
          end
        end
      end
    end
  end

  // Pin level is high when the active state matches the polarity bit
  always_comb begin
    pol_used = regs[`SOC_POL_IDX] >> BASE;
    for (int i = 0; i < `SOC_NUM_OUT; i++) begin
      level[i] = (i < NUSED) ? (active[i] == pol_used[i]) : 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_drive_low  <= '0;
      pin_drive_high <= '0;
      pin_pullup_en  <= '0;
      pin_pump_en    <= '0;
      pin_ref_sel    <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < `SOC_NUM_OUT; i++) begin
        pin_ref_sel[3*i +: 3] <= rsel[i];
        pin_drive_low[i]  <= (i < NUSED) && !level[i];
        pin_drive_high[i] <= level[i] && kind[i] == soc_push_pull;
        pin_pullup_en[i]  <= level[i] && kind[i] == soc_weak_pullup;
        pin_pump_en[i]    <= level[i] && kind[i] == soc_charge_pump;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/soc_output_config_checker.sv
// Purpose: Port-level relations of the output configuration block.
// Assumes: One clock, rst synchronous active high.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module soc_output_config_checker #(
  parameter bit FIVE_OUT = 1'b0
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       rd_en,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] assert_req,
  input wire logic [7:0] rdata,
  input wire logic       rd_valid,
  input wire logic       rd_error,
  input wire logic       reloading,
  input wire logic [7:0] pin_drive_low,
  input wire logic [7:0] pin_drive_high,
  input wire logic [7:0] pin_pump_en,
  input wire logic [7:0] deassert_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_PUMP_GROUP: assert property ((pin_pump_en >> (FIVE_OUT ? 2 : 4)) == 8'h00)
    else $error("charge pump on a high-group output");
  AST_PP_GROUP: assert property ((pin_drive_high & (FIVE_OUT ? 8'h03 : 8'h0F)) == 8'h00)
    else $error("push-pull drive on a low-group output");
  AST_NO_FIGHT: assert property ((pin_drive_low & pin_drive_high) == 8'h00)
    else $error("output driven high and low at once");
  AST_IDLE_AFTER_RST: assert property ($fell(rst) |-> (pin_drive_low | pin_drive_high | pin_pump_en) == 8'h00)
    else $error("output active right after reset");
  AST_READ_ANSWER: assert property (clk_en && rd_en |=> rd_valid || rd_error)
    else $error("read not answered next cycle");
  AST_UNMAPPED_ZERO: assert property (rd_error |-> rdata == 8'h00)
    else $error("refused read carries data");
  AST_REBOOT: assert property (clk_en && cmd_valid && cmd_byte == 8'h88 |-> ##[1:2] reloading)
    else $error("reboot command gave no reload");
  AST_DONE_ONE: assert property ($past(clk_en) |-> (deassert_done & $past(deassert_done)) == 8'h00)
    else $error("timeout end longer than one cycle");
  AST_DONE_RELEASED: assert property ($past(clk_en) |-> (deassert_done & $past(assert_req)) == 8'h00)
    else $error("timeout ended while still asserted");
  cover property (reloading);
  cover property (|deassert_done);
  cover property (rd_error);
  cover property (|pin_pump_en);
endmodule
`default_nettype wire

// ===== verification/soc_output_config_tb.sv
// Purpose: Self-checking bench for the output configuration block.
// Assumes: Both variants side by side on shared inputs; clk_en low only in the freeze check.
// Notes:   Reads are noted in a queue and matched by a monitor.
`include "soc_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module soc_output_config_tb;
  logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0, cmd_valid = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, cmd_byte = 8'h00, assert_req = 8'hFF, seed = 8'h4A;
  logic [71:0] nv_image = '0;
  logic [7:0]  rdata, pin_drive_low, pin_drive_high, pin_pullup_en, pin_pump_en, deassert_done;
  logic        rd_valid, rd_error, reloading;
  logic [23:0] pin_ref_sel;
  logic [7:0]  f_low, f_high, f_pu, f_pump;
  logic [23:0] f_ref;
  logic [8:0]  notes[$];
  logic [7:0]  shadow [9];
  logic [7:0]  ofs [9] = '{8'h11, 8'h15, 8'h1C, 8'h23, 8'h2A, 8'h31, 8'h35, 8'h39, 8'h3A};
  int          errors = 0, n_checks = 0, n;
  soc_output_config #(.FIVE_OUT(1'b0)) i_soc_output_config (.clock, .rst, .clk_en, .wr_en, .rd_en, .addr, .wdata,
    .cmd_valid, .cmd_byte, .nv_image, .assert_req, .rdata, .rd_valid, .rd_error, .reloading, .pin_drive_low,
    .pin_drive_high, .pin_pullup_en, .pin_pump_en, .pin_ref_sel, .deassert_done);
  // Five-output variant watched only on its pins; reads are answered alike by both
  soc_output_config #(.FIVE_OUT(1'b1)) i_soc_output_config_five (.clock, .rst, .clk_en, .wr_en, .rd_en, .addr,
    .wdata, .cmd_valid, .cmd_byte, .nv_image, .assert_req, .rdata(), .rd_valid(), .rd_error(), .reloading(),
    .pin_drive_low(f_low), .pin_drive_high(f_high), .pin_pullup_en(f_pu), .pin_pump_en(f_pump),
    .pin_ref_sel(f_ref), .deassert_done());
  always #50 clock = ~clock;
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task report_and_stop;
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    notes.push_back(e);
    @(posedge clock);
    rd_en <= 1'b0;
  endtask
  task cmd(input logic [7:0] b);
    @(posedge clock);
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  // Pins settle one cycle after the write; two more give margin
  task stg(input logic [7:0] a, d, input int ch, input logic [3:0] p, input logic [2:0] r);
    wr(a, d);
    repeat (3) @(posedge clock);
    `CHK("pins", p, {pin_drive_low[ch], pin_drive_high[ch], pin_pullup_en[ch], pin_pump_en[ch]})
    if (r != 3'h7) `CHK("ref", r, pin_ref_sel[3*ch +: 3])
  endtask
  task two(input logic [7:0] a, d, input int ch, input logic [3:0] p, input logic [2:0] r, input int fc,
           input logic [3:0] fp, input logic [2:0] fr);
    stg(a, d, ch, p, r);
    `CHK("pins5", fp, {f_low[fc], f_high[fc], f_pu[fc], f_pump[fc]})
    if (fr != 3'h7) `CHK("ref5", fr, f_ref[3*fc +: 3])
  endtask
  task tmo(input logic [2:0] t, input int p);
    wr(8'h2A, 8'h60 | {4'h0, t, 1'b0});
    @(posedge clock);
    assert_req[4] <= 1'b0;
    n = 0;
    while (deassert_done[4] !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    `CHK("period", 1'b1, n >= p - 2 && n <= p + 2)
    if (n >= 20000) report_and_stop();
    else begin
      repeat (2) @(posedge clock);
      `CHK("released", 2'b10, {pin_drive_low[4], pin_drive_high[4]})
      assert_req[4] <= 1'b1;
    end
  endtask
  always @(posedge clock) if (rd_valid === 1'b1 || rd_error === 1'b1) `CHK("read", notes.pop_front(), {rd_error, rdata})
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(ofs[i], {1'b0, i == 8 ? 8'hFF : 8'h00});
    rd(8'h12, 9'h100);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      shadow[i] = seed;
      wr(ofs[i], seed);
    end
    wr(8'h12, 8'h55);
    for (int i = 0; i < 9; i++) rd(ofs[i], {1'b0, shadow[i]});
    wr(8'h3A, 8'hFF);
    stg(8'h11, 8'h60, 0, 4'h1, 3'h7);
    stg(8'h11, 8'h50, 0, 4'h2, 3'h4);
    stg(8'h11, 8'h40, 0, 4'h2, 3'h3);
    stg(8'h11, 8'h70, 0, 4'h0, 3'h7);
    stg(8'h1C, 8'hC0, 2, 4'h1, 3'h7);
    stg(8'h2A, 8'h60, 4, 4'h4, 3'h0);
    stg(8'h39, 8'h90, 7, 4'h4, 3'h3);
    stg(8'h2A, 8'h10, 4, 4'h2, 3'h0);
    stg(8'h2A, 8'hA0, 4, 4'h0, 3'h7);
    stg(8'h2A, 8'h00, 4, 4'h0, 3'h7);
    stg(8'h3A, 8'h00, 4, 4'h8, 3'h7);
    stg(8'h2A, 8'h60, 4, 4'h8, 3'h7);
    stg(8'h3A, 8'hFF, 4, 4'h4, 3'h7);
    two(8'h1C, 8'h60, 2, 4'h2, 3'h2, 0, 4'h0, 3'h7);
    two(8'h1C, 8'h40, 2, 4'h2, 3'h1, 0, 4'h2, 3'h1);
    two(8'h1C, 8'hC0, 2, 4'h1, 3'h7, 0, 4'h1, 3'h7);
    two(8'h2A, 8'h70, 4, 4'h4, 3'h1, 2, 4'h4, 3'h1);
    two(8'h2A, 8'h80, 4, 4'h4, 3'h2, 2, 4'h0, 3'h7);
    two(8'h2A, 8'h30, 4, 4'h2, 3'h2, 2, 4'h0, 3'h7);
    tmo(3'h0, `SOC_T0_NS / `SOC_CLK_NS);
    tmo(3'h1, `SOC_T1_NS / `SOC_CLK_NS);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      shadow[i] = seed;
      nv_image[8*i +: 8] <= seed;
    end
    cmd(8'h87);
    rd(8'h11, 9'h070);
    // Let the read answer clear before freezing, or the frozen pulse would be seen three times
    repeat (2) @(posedge clock);
    clk_en <= 1'b0;
    wr(8'h11, 8'h33);
    clk_en <= 1'b1;
    rd(8'h11, 9'h070);
    cmd(8'h88);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (reloading !== 1'b1 && n < 4);
    `CHK("reload", 1'b1, reloading)
    for (int i = 0; i < 9; i++) rd(ofs[i], {1'b0, shadow[i]});
    repeat (4) @(posedge clock);
    `CHK("pending", 32'd0, 32'(notes.size()))
    report_and_stop();
  end
endmodule
bind soc_output_config soc_output_config_checker #(.FIVE_OUT(FIVE_OUT)) i_soc_output_config_checker (.clock, .rst,
  .clk_en, .rd_en, .cmd_valid, .cmd_byte, .assert_req, .rdata, .rd_valid, .rd_error, .reloading, .pin_drive_low,
  .pin_drive_high, .pin_pump_en, .deassert_done);
`default_nettype wire
